// ===== dv/scie_asserts.sv
/* port checker of the status clear block.
   bound to every scie_top, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module scie_asserts
  import scie_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cmd_error_set,
  input wire logic draw_break_set,
  input wire logic [15:0] status_flags,
  input wire logic irq_n
);
  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_IRQ_SRC: assert property (!irq_n |-> $past(status_flags) != 16'h0000)
    else $error("irq low without flag");
  AST_IRQ_RST: assert property ($rose(aresetn) |-> irq_n)
    else $error("irq low after reset");
  AST_FLAG_POS: assert property ((status_flags & ~SCIE_FLAG_MASK) == 16'h0000)
    else $error("flag at reserved bit");
  AST_BRK_SET: assert property (draw_break_set |=> status_flags[7])
    else $error("break set lost");
  AST_CER_SET: assert property (cmd_error_set |=> status_flags[12])
    else $error("cmd error set lost");
  AST_FLAG_HOLD: assert property ($fell(status_flags[14]) |-> $rose(s_axi_bvalid))
    else $error("flag fell without write");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  COV_IRQ: cover property (!irq_n);
  COV_CLR: cover property ($fell(status_flags[7]));
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind scie_top scie_asserts u_scie_asserts (.*);
`default_nettype wire

// ===== dv/scie_evt_model.sv
/* flag event source model.
   registers a request vector onto the set inputs, one aclk cycle later. */
`timescale 1ns/1ns
`default_nettype none
module scie_evt_model (
  input wire logic aclk,
  input wire logic [15:0] fire,
  output logic [15:0] set_bits
);
  always_ff @(posedge aclk) begin
    set_bits <= fire;
  end
endmodule
`default_nettype wire

// ===== dv/status_clear_and_irq_enable_bench.sv
/* testbench of the status clear block.
   drives AXI4-Lite and flag events, 100 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module status_clear_and_irq_enable_bench;
  import scie_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, irq_n;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] status_flags, ev, fire;
  int failures = 0;
  int checks_done = 0;
  scie_top u_scie_top (.*, .sync_error_set(ev[15]), .frame_set(ev[14]), .dma_done_set(ev[13]),
    .cmd_error_set(ev[12]), .vblank_set(ev[11]), .cmd_end_set(ev[10]), .suspend_set(ev[9]),
    .draw_break_set(ev[7]));
  scie_evt_model u_scie_evt_model (.aclk(aclk), .fire(fire), .set_bits(ev));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    logic ta, tw, tr, tb, td;
    int n;
    n = 0;
    tb = 1'b0;
    td = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    s_axi_awaddr <= {28'h0, a};
    s_axi_araddr <= {28'h0, a};
    s_axi_wdata <= {16'h0, d};
    while (!(tb || td)) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = s_axi_bready && s_axi_bvalid;
      td = s_axi_rready && s_axi_rvalid;
      r = tb ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (td) s_axi_rready <= 1'b0;
      n++;
      if (n > 40) begin
        failures++;
        complete_run();
      end
    end
  endtask
  task pulse(input int b);
    @(posedge aclk);
    fire <= 16'h0001 << b;
    @(posedge aclk);
    fire <= 16'h0000;
    repeat (3) @(negedge aclk);
  endtask
  // ------------------------------------------
  // sequence
  // ------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot, fire} = 118'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    acc(1'b0, SCIE_OFS_MASK, 16'h0000);
    chk(q, 32'h0);
    acc(1'b1, SCIE_OFS_MASK, SCIE_FLAG_MASK);
    chk(r, SCIE_RESP_OKAY);
    acc(1'b0, SCIE_OFS_MASK, 16'h0000);
    chk(q, {16'h0, SCIE_FLAG_MASK});
    acc(1'b1, SCIE_OFS_STATUS, 16'hFFFF);
    chk(r, SCIE_RESP_SLVERR);
    for (int i = 7; i < 16; i++) begin
      if (SCIE_FLAG_MASK[i]) begin
        acc(1'b1, SCIE_OFS_MASK, 16'h0000);
        pulse(i);
        chk(irq_n, 1'b1);
        acc(1'b1, SCIE_OFS_MASK, 16'h0001 << i);
        repeat (2) @(negedge aclk);
        chk(irq_n, 1'b0);
        acc(1'b1, SCIE_OFS_CLEAR, SCIE_FLAG_MASK & ~(16'h0001 << i));
        acc(1'b0, SCIE_OFS_STATUS, 16'h0000);
        chk(q, 32'h1 << i);
        acc(1'b1, SCIE_OFS_CLEAR, 16'h0001 << i);
        acc(1'b0, SCIE_OFS_STATUS, 16'h0000);
        chk(q, 32'h0);
        chk(irq_n, 1'b1);
      end
    end
    fire <= 16'h1000;
    acc(1'b1, SCIE_OFS_CLEAR, 16'h1000);
    fire <= 16'h0000;
    @(negedge aclk);
    chk(status_flags, 16'h1000);
    acc(1'b1, SCIE_OFS_CLEAR, 16'h1000);
    @(negedge aclk);
    chk(status_flags, 16'h0000);
    acc(1'b0, SCIE_OFS_CLEAR, 16'h0000);
    chk(q, 32'h0);
    acc(1'b1, SCIE_OFS_MASK, SCIE_FLAG_MASK);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    acc(1'b0, SCIE_OFS_MASK, 16'h0000);
    chk(q, 32'h0);
    s_axi_wstrb <= 4'h2;
    acc(1'b1, SCIE_OFS_MASK, SCIE_FLAG_MASK);
    s_axi_wstrb <= 4'hF;
    acc(1'b0, SCIE_OFS_MASK, 16'h0000);
    chk(q, {16'h0, SCIE_FLAG_MASK & 16'hFF00});
    acc(1'b0, SCIE_OFS_ID, 16'h0000);
    chk(q, {16'h0, SCIE_ID_DEFAULT});
    complete_run();
  end
endmodule
`default_nettype wire

// ===== logic/scie_pkg.sv
/*
  shared constants and types of the status clear and interrupt enable block.
  assumes a 32-bit AXI4-Lite register bus with registers on aligned words.
*/
`default_nettype none
package scie_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SCIE_OFS_STATUS = 4'h0;
  localparam logic [3:0] SCIE_OFS_CLEAR = 4'h4;
  localparam logic [3:0] SCIE_OFS_MASK = 4'h8;
  localparam logic [3:0] SCIE_OFS_ID = 4'hC;
  localparam int SCIE_ADDR_W = 4;
  localparam int SCIE_REG_W = 16;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SCIE_BIT_SYNC_ERROR = 15;
  localparam int SCIE_BIT_FRAME = 14;
  localparam int SCIE_BIT_DMA_DONE = 13;
  localparam int SCIE_BIT_CMD_ERROR = 12;
  localparam int SCIE_BIT_VBLANK = 11;
  localparam int SCIE_BIT_CMD_END = 10;
  localparam int SCIE_BIT_SUSPEND = 9;
  localparam int SCIE_BIT_DRAW_BREAK = 7;
  localparam logic [15:0] SCIE_FLAG_MASK = 16'hFE80;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] SCIE_RST_MASK = 16'h0000;
  localparam logic [15:0] SCIE_RST_FLAGS = 16'h0000;
  localparam logic [1:0] SCIE_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCIE_RESP_SLVERR = 2'h2;
  // arbitrary identification value
  localparam logic [15:0] SCIE_ID_DEFAULT = 16'h5A5A;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } scie_rd_t;

endpackage
`default_nettype wire

// ===== logic/scie_top.sv
/*
  status flag clear register, interrupt mask register and active-low
  interrupt request, reached over AXI4-Lite.
  assumes flag set events are one-cycle pulses on aclk from the same domain.
*/
// What this block does
// - write-one clear register over eight flag bits
// - clear register always reads back zero
// - bit 15 clears sync error flag
// - bit 14 clears frame flag
// - bit 13 clears dma done flag
// - bit 12 clears command error flag
// - bit 11 clears vertical blanking flag
// - bit 10 clears command end flag
// - bit 9 clears command suspend flag
// - bit 7 clears drawing break flag
// - read/write mask register gates each flag
// - mask bits 15..9,7 gate flags in order
// - irq_n low when any flag and mask set
// - drawing break flag raises irq like others
// - mask bits reset to zero
// - flags stay set until reset or clear
// - flags share bit positions with clear bits
`timescale 1ns/1ns
`default_nettype none
module scie_top
  import scie_pkg::*;
#(
  parameter logic [15:0] ID_VALUE = SCIE_ID_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_error_set,
  input wire logic frame_set,
  input wire logic dma_done_set,
  input wire logic cmd_error_set,
  input wire logic vblank_set,
  input wire logic cmd_end_set,
  input wire logic suspend_set,
  input wire logic draw_break_set,
  output logic [15:0] status_flags,
  output logic irq_n
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // word offset of a bus address; upper address bits alias
  function automatic logic [SCIE_ADDR_W-1:0] word_offset(input logic [31:0] addr);
    word_offset = {addr[SCIE_ADDR_W-1:2], 2'b00};
  endfunction

  // one flag bit: a set event beats a clear in the same cycle
  function automatic logic flag_next(input logic flag, input logic set_evt, input logic clr);
    flag_next = set_evt || (flag && !clr);
  endfunction

  // one interrupt term: a flag passes only with its mask bit
  function automatic logic irq_term(input logic flag, input logic enable);
    irq_term = flag && enable;
  endfunction

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [SCIE_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] interrupt_mask;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  // a write fires once both halves are held and no response is pending
  wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_clear = wr_fire && (aw_addr == SCIE_OFS_CLEAR);
  wire logic wr_mask = wr_fire && (aw_addr == SCIE_OFS_MASK);
  wire logic wr_ok = wr_clear || wr_mask;
  wire logic [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // address and data arrive in either order; each waits here for the other
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= word_offset(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // handshake readies
  // ----------------------------------------------------------------
  // ready drops after each pulse so a held valid is never taken twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_awready;
      s_axi_wready <= !w_held && !w_take && !s_axi_wready;
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SCIE_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? SCIE_RESP_OKAY : SCIE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // flags, clear pulse and mask
  // ----------------------------------------------------------------
  // the clear pulse lives for one cycle only, so nothing stores it
  wire logic [15:0] clear_pulse = wr_clear ? (w_data[15:0] & lane_mask & SCIE_FLAG_MASK) : 16'h0000;
  wire logic [15:0] next_mask = ((interrupt_mask & ~lane_mask) | (w_data[15:0] & lane_mask)) & SCIE_FLAG_MASK;

  // ----------------------------------------------------------------
  // per-flag clear strobes, present flags and mask bits
  // ----------------------------------------------------------------
  wire logic sync_error_clear = clear_pulse[SCIE_BIT_SYNC_ERROR];
  wire logic frame_flag_clear = clear_pulse[SCIE_BIT_FRAME];
  wire logic dma_done_clear = clear_pulse[SCIE_BIT_DMA_DONE];
  wire logic cmd_error_clear = clear_pulse[SCIE_BIT_CMD_ERROR];
  wire logic vblank_clear = clear_pulse[SCIE_BIT_VBLANK];
  wire logic cmd_end_clear = clear_pulse[SCIE_BIT_CMD_END];
  wire logic suspend_clear = clear_pulse[SCIE_BIT_SUSPEND];
  wire logic draw_break_clear = clear_pulse[SCIE_BIT_DRAW_BREAK];

  wire logic sync_error_flag = status_flags[SCIE_BIT_SYNC_ERROR];
  wire logic frame_flag = status_flags[SCIE_BIT_FRAME];
  wire logic dma_done_flag = status_flags[SCIE_BIT_DMA_DONE];
  wire logic cmd_error_flag = status_flags[SCIE_BIT_CMD_ERROR];
  wire logic vblank_flag = status_flags[SCIE_BIT_VBLANK];
  wire logic cmd_end_flag = status_flags[SCIE_BIT_CMD_END];
  wire logic suspend_flag = status_flags[SCIE_BIT_SUSPEND];
  wire logic draw_break_flag = status_flags[SCIE_BIT_DRAW_BREAK];

  wire logic sync_error_enable = interrupt_mask[SCIE_BIT_SYNC_ERROR];
  wire logic frame_enable = interrupt_mask[SCIE_BIT_FRAME];
  wire logic dma_done_enable = interrupt_mask[SCIE_BIT_DMA_DONE];
  wire logic cmd_error_enable = interrupt_mask[SCIE_BIT_CMD_ERROR];
  wire logic vblank_enable = interrupt_mask[SCIE_BIT_VBLANK];
  wire logic cmd_end_enable = interrupt_mask[SCIE_BIT_CMD_END];
  wire logic suspend_enable = interrupt_mask[SCIE_BIT_SUSPEND];
  wire logic draw_break_enable = interrupt_mask[SCIE_BIT_DRAW_BREAK];

  // ----------------------------------------------------------------
  // next flag values and interrupt terms
  // ----------------------------------------------------------------
  // flags keep their bit positions; bit 8 and bits 6..0 stay zero
  wire logic [15:0] next_flags = {
    flag_next(sync_error_flag, sync_error_set, sync_error_clear),
    flag_next(frame_flag, frame_set, frame_flag_clear),
    flag_next(dma_done_flag, dma_done_set, dma_done_clear),
    flag_next(cmd_error_flag, cmd_error_set, cmd_error_clear),
    flag_next(vblank_flag, vblank_set, vblank_clear),
    flag_next(cmd_end_flag, cmd_end_set, cmd_end_clear),
    flag_next(suspend_flag, suspend_set, suspend_clear),
    1'b0,
    flag_next(draw_break_flag, draw_break_set, draw_break_clear),
    7'h00
  };

  wire logic sync_error_irq = irq_term(sync_error_flag, sync_error_enable);
  wire logic frame_irq = irq_term(frame_flag, frame_enable);
  wire logic dma_done_irq = irq_term(dma_done_flag, dma_done_enable);
  wire logic cmd_error_irq = irq_term(cmd_error_flag, cmd_error_enable);
  wire logic vblank_irq = irq_term(vblank_flag, vblank_enable);
  wire logic cmd_end_irq = irq_term(cmd_end_flag, cmd_end_enable);
  wire logic suspend_irq = irq_term(suspend_flag, suspend_enable);
  wire logic draw_break_irq = irq_term(draw_break_flag, draw_break_enable);
  wire logic irq_any = sync_error_irq || frame_irq || dma_done_irq || cmd_error_irq ||
    vblank_irq || cmd_end_irq || suspend_irq || draw_break_irq;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_flags <= SCIE_RST_FLAGS;
    end else begin
      status_flags <= next_flags;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_mask <= SCIE_RST_MASK;
    end else if (wr_mask) begin
      interrupt_mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // registered so a settling flag or mask term never glitches the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !irq_any;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [SCIE_ADDR_W-1:0] rd_addr = word_offset(s_axi_araddr);
  wire logic rd_status = (rd_addr == SCIE_OFS_STATUS);
  wire logic rd_clear = (rd_addr == SCIE_OFS_CLEAR);
  wire logic rd_mask = (rd_addr == SCIE_OFS_MASK);
  wire logic rd_id = (rd_addr == SCIE_OFS_ID);
  // one answer word per register, then the address picks one
  wire scie_rd_t status_word = scie_rd_t'{data: {16'h0000, status_flags}, resp: SCIE_RESP_OKAY};
  wire scie_rd_t clear_word = scie_rd_t'{data: 32'h00000000, resp: SCIE_RESP_OKAY};
  wire scie_rd_t mask_word = scie_rd_t'{data: {16'h0000, interrupt_mask}, resp: SCIE_RESP_OKAY};
  wire scie_rd_t id_word = scie_rd_t'{data: {16'h0000, ID_VALUE}, resp: SCIE_RESP_OKAY};
  wire scie_rd_t miss_word = scie_rd_t'{data: 32'h00000000, resp: SCIE_RESP_SLVERR};
  wire scie_rd_t rd_word = rd_status ? status_word :
    rd_clear ? clear_word :
    rd_mask ? mask_word :
    rd_id ? id_word :
    miss_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= SCIE_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word.data;
      s_axi_rresp <= rd_word.resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire
